// ### cpe_console_regs.vh
// constants for the console program entry block
`ifndef CPE_CONSOLE_REGS_VH
`define CPE_CONSOLE_REGS_VH

// program word layout: {op, class, data}
`define CPE_OP_W 5
`define CPE_SUB_W 3
`define CPE_DATA_W 12
`define CPE_WORD_W 20
`define CPE_ADDR_W 8
`define CPE_DEPTH 256
`define CPE_ADDR_FIRST 8'h00
`define CPE_ADDR_LAST 8'hFF
`define CPE_ADDR_MAX 10'h0FF
`define CPE_OP_EMPTY 5'h1F
`define CPE_SUB_ZERO 3'h0
`define CPE_DATA_ZERO 12'h000
`define CPE_WORD_EMPTY 20'hF8000

// mode selector positions
`define CPE_MODE_RUN 2'h0
`define CPE_MODE_STOP 2'h1
`define CPE_MODE_PROG 2'h2

// key codes
`define CPE_KEY_DIG_MAX 6'h09
`define CPE_KEY_CLEAR 6'h0A
`define CPE_KEY_WRITE 6'h0B
`define CPE_KEY_READ 6'h0C
`define CPE_KEY_FWD 6'h0D
`define CPE_KEY_BACK 6'h0E
`define CPE_KEY_DISCARD 6'h0F
`define CPE_KEY_NOT 6'h10
`define CPE_KEY_MONITOR 6'h11
`define CPE_KEY_FUNC 6'h12
`define CPE_KEY_EPR_WR 6'h13
`define CPE_KEY_EPR_RD 6'h14
`define CPE_KEY_EPR_VF 6'h15
`define CPE_KEY_TAPE_WR 6'h16
`define CPE_KEY_TAPE_RD 6'h17
`define CPE_KEY_TAPE_VF 6'h18
// op keys 0x20..0x2F, class keys 0x30..0x37
`define CPE_KEY_GRP_OP 2'h2
`define CPE_KEY_GRP_SUB 2'h3

// four-key all-clear sequence
`define CPE_AC_KEY0 6'h12
`define CPE_AC_KEY1 6'h01
`define CPE_AC_KEY2 6'h10
`define CPE_AC_KEY3 6'h11
`define CPE_AC_LAST 2'h3

`endif

// ### cpe_prog_ram.v
// program word store, one write port and one registered read port
`timescale 1ns/1ps
`include "cpe_console_regs.vh"

module cpe_prog_ram (
  // clock
  input wire ref_clk,
  // write port
  input wire we,
  input wire [`CPE_ADDR_W-1:0] waddr,
  input wire [`CPE_WORD_W-1:0] wdata,
  // read port
  input wire [`CPE_ADDR_W-1:0] raddr,
  output reg [`CPE_WORD_W-1:0] rdata
);

  // no reset: contents must survive, the array stands for battery backed ram
  reg [`CPE_WORD_W-1:0] mem [0:`CPE_DEPTH-1];

  always @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // cpe_prog_ram

// ### cpe_console_entry.v
// keypad command interpreter for the program memory console
`timescale 1ns/1ps
`include "cpe_console_regs.vh"

// Summary of operation
// - memory survives power loss, needs all-clear
// - all-clear empties addresses 000 to 255
// - beep on every accepted all-clear key
// - clear key or stray key aborts all-clear
// - address is up to three decimal digits
// - no digits after clear means 000
// - address above 255 drops leading digit
// - address alone does not show word
// - write stores fields then bumps address
// - cleared word reads empty op, zeros
// - discard key drops pending fields, restart
// - eprom store, load and compare commands
// - tape record, load and compare commands
// - step forward shows address plus one
// - step back shows address minus one
module cpe_console_entry (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // keypad and mode selector pins
  input wire key_strobe,
  input wire [5:0] key_code,
  input wire [1:0] mode_sel,
  // display
  output reg [`CPE_ADDR_W-1:0] disp_addr,
  output reg [`CPE_OP_W-1:0] disp_op,
  output reg [`CPE_SUB_W-1:0] disp_sub,
  output reg [`CPE_DATA_W-1:0] disp_data,
  output reg disp_show,
  output reg beep,
  output reg busy,
  output reg verify_fail,
  // eprom / tape transfer port, same clock domain
  output reg xfer_req,
  output reg xfer_tape,
  output reg xfer_load,
  output reg [1:0] xfer_bank,
  output reg [`CPE_ADDR_W-1:0] xfer_addr,
  output reg [`CPE_WORD_W-1:0] xfer_wdata,
  input wire [`CPE_WORD_W-1:0] xfer_rdata,
  input wire xfer_ack
);

  localparam [6:0] ST_IDLE = 7'b0000001;
  localparam [6:0] ST_RD1 = 7'b0000010;
  localparam [6:0] ST_RD2 = 7'b0000100;
  localparam [6:0] ST_CLR = 7'b0001000;
  localparam [6:0] ST_XRAM = 7'b0010000;
  localparam [6:0] ST_XLAT = 7'b0100000;
  localparam [6:0] ST_XREQ = 7'b1000000;

  // three bcd digits to an address, leading digit forced to zero above 255
  function [`CPE_ADDR_W-1:0] bcd_addr;
    input [3:0] hun;
    input [3:0] ten;
    input [3:0] one;
    reg [9:0] full;
    reg [9:0] low;
    begin
      low = {6'h00, ten} * 10'h00A + {6'h00, one};
      full = {6'h00, hun} * 10'h064 + low;
      if (full > `CPE_ADDR_MAX) begin
        bcd_addr = low[`CPE_ADDR_W-1:0];
      end else begin
        bcd_addr = full[`CPE_ADDR_W-1:0];
      end
    end
  endfunction

  // same test reused for the stored digits
  function over_max;
    input [3:0] hun;
    input [3:0] ten;
    input [3:0] one;
    reg [9:0] full;
    begin
      full = {6'h00, hun} * 10'h064 + {6'h00, ten} * 10'h00A + {6'h00, one};
      over_max = (full > `CPE_ADDR_MAX);
    end
  endfunction

  // pin synchronisers
  reg strobe_s1, strobe_s2, strobe_s3;
  reg [5:0] code_s1, code_s2;
  reg [1:0] mode_s1, mode_s2, mode_prev;

  reg [6:0] state;
  reg [`CPE_ADDR_W-1:0] work;
  reg [3:0] dig_hun, dig_ten;
  reg addr_mode;
  reg ac_armed;
  reg [1:0] ac_step;
  reg xfer_verify;
  reg ram_we;
  reg [`CPE_ADDR_W-1:0] ram_wa;
  reg [`CPE_WORD_W-1:0] ram_wd;
  wire [`CPE_WORD_W-1:0] ram_rdata;
  reg [`CPE_ADDR_W-1:0] ram_ra;
  reg [5:0] ac_key;

  wire key_hit = strobe_s2 & ~strobe_s3;
  wire [5:0] key = code_s2;
  wire in_prog = (mode_s2 == `CPE_MODE_PROG);
  wire is_digit = (key <= `CPE_KEY_DIG_MAX);
  wire is_op = (key[5:4] == `CPE_KEY_GRP_OP);
  wire is_sub = (key[5:4] == `CPE_KEY_GRP_SUB) && !key[3];
  wire [`CPE_WORD_W-1:0] fields = {disp_op, disp_sub, disp_data};
  wire bulk_key = (key >= `CPE_KEY_EPR_WR) && (key <= `CPE_KEY_TAPE_VF);

  always @* begin
    ram_ra = disp_addr;
    if (state != ST_IDLE && state != ST_RD1 && state != ST_RD2) begin
      ram_ra = work;
    end
  end

  always @* begin
    case (ac_step)
      2'h0: ac_key = `CPE_AC_KEY0;
      2'h1: ac_key = `CPE_AC_KEY1;
      2'h2: ac_key = `CPE_AC_KEY2;
      default: ac_key = `CPE_AC_KEY3;
    endcase
  end

  cpe_prog_ram u_ram (
    .ref_clk(ref_clk),
    .we(ram_we),
    .waddr(ram_wa),
    .wdata(ram_wd),
    .raddr(ram_ra),
    .rdata(ram_rdata)
  );

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      code_s1 <= 6'h00;
      code_s2 <= 6'h00;
      mode_s1 <= `CPE_MODE_STOP;
      mode_s2 <= `CPE_MODE_STOP;
      mode_prev <= `CPE_MODE_STOP;
    end else begin
      strobe_s1 <= key_strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      code_s1 <= key_code;
      code_s2 <= code_s1;
      mode_s1 <= mode_sel;
      mode_s2 <= mode_s1;
      mode_prev <= mode_s2;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      work <= `CPE_ADDR_FIRST;
      dig_hun <= 4'h0;
      dig_ten <= 4'h0;
      addr_mode <= 1'b1;
      ac_armed <= 1'b0;
      ac_step <= 2'h0;
      xfer_verify <= 1'b0;
      ram_we <= 1'b0;
      ram_wa <= `CPE_ADDR_FIRST;
      ram_wd <= `CPE_WORD_EMPTY;
      disp_addr <= `CPE_ADDR_FIRST;
      disp_op <= `CPE_OP_EMPTY;
      disp_sub <= `CPE_SUB_ZERO;
      disp_data <= `CPE_DATA_ZERO;
      disp_show <= 1'b0;
      beep <= 1'b0;
      busy <= 1'b0;
      verify_fail <= 1'b0;
      xfer_req <= 1'b0;
      xfer_tape <= 1'b0;
      xfer_load <= 1'b0;
      xfer_bank <= 2'h0;
      xfer_addr <= `CPE_ADDR_FIRST;
      xfer_wdata <= `CPE_WORD_EMPTY;
    end else begin
      ram_we <= 1'b0;
      beep <= 1'b0;
      case (state)
        ST_IDLE: begin
          busy <= 1'b0;
          if (key_hit && in_prog && ac_armed && key == ac_key) begin
            beep <= 1'b1;
            ac_step <= ac_step + 2'h1;
            if (ac_step == `CPE_AC_LAST) begin
              ac_armed <= 1'b0;
              work <= `CPE_ADDR_FIRST;
              busy <= 1'b1;
              state <= ST_CLR;
            end
          end else if (key_hit && in_prog) begin
            ac_armed <= 1'b0;
            if (key == `CPE_KEY_CLEAR) begin
              disp_addr <= `CPE_ADDR_FIRST;
              dig_hun <= 4'h0;
              dig_ten <= 4'h0;
              addr_mode <= 1'b1;
              disp_show <= 1'b0;
            end else if (is_digit && addr_mode) begin
              // new digit enters at the right, address follows each key
              disp_addr <= bcd_addr(dig_hun, dig_ten, key[3:0]);
              if (over_max(dig_hun, dig_ten, key[3:0])) begin
                dig_hun <= 4'h0;
              end else begin
                dig_hun <= dig_ten;
              end
              dig_ten <= key[3:0];
              disp_show <= 1'b0;
            end else if (is_digit) begin
              disp_data <= {disp_data[7:0], key[3:0]};
            end else if (is_op) begin
              addr_mode <= 1'b0;
              disp_op <= {1'b0, key[3:0]};
              disp_sub <= `CPE_SUB_ZERO;
              disp_data <= `CPE_DATA_ZERO;
            end else if (is_sub) begin
              addr_mode <= 1'b0;
              disp_sub <= key[2:0];
            end else if (key == `CPE_KEY_WRITE) begin
              ram_we <= 1'b1;
              ram_wa <= disp_addr;
              ram_wd <= fields;
              disp_addr <= disp_addr + 8'h01;
              disp_op <= `CPE_OP_EMPTY;
              disp_sub <= `CPE_SUB_ZERO;
              disp_data <= `CPE_DATA_ZERO;
              disp_show <= 1'b0;
              addr_mode <= 1'b0;
            end else if (key == `CPE_KEY_DISCARD) begin
              disp_op <= `CPE_OP_EMPTY;
              disp_sub <= `CPE_SUB_ZERO;
              disp_data <= `CPE_DATA_ZERO;
              addr_mode <= 1'b0;
            end else if (key == `CPE_KEY_READ) begin
              busy <= 1'b1;
              addr_mode <= 1'b0;
              state <= ST_RD1;
            end else if (key == `CPE_KEY_FWD && disp_show) begin
              disp_addr <= disp_addr + 8'h01;
              busy <= 1'b1;
              state <= ST_RD1;
            end else if (key == `CPE_KEY_BACK && disp_show) begin
              disp_addr <= disp_addr - 8'h01;
              busy <= 1'b1;
              state <= ST_RD1;
            end else if (bulk_key) begin
              // bank number is the low bits of the keyed data field
              xfer_bank <= disp_data[1:0];
              xfer_tape <= (key >= `CPE_KEY_TAPE_WR);
              xfer_load <= (key == `CPE_KEY_EPR_RD) ||
                           (key == `CPE_KEY_TAPE_RD);
              xfer_verify <= (key == `CPE_KEY_EPR_VF) ||
                             (key == `CPE_KEY_TAPE_VF);
              verify_fail <= 1'b0;
              work <= `CPE_ADDR_FIRST;
              busy <= 1'b1;
              state <= ST_XRAM;
            end
          end
        end
        ST_RD1: begin
          state <= ST_RD2;
        end
        ST_RD2: begin
          // display only, nothing is written back
          disp_op <= ram_rdata[19:15];
          disp_sub <= ram_rdata[14:12];
          disp_data <= ram_rdata[11:0];
          disp_show <= 1'b1;
          state <= ST_IDLE;
        end
        ST_CLR: begin
          ram_we <= 1'b1;
          ram_wa <= work;
          ram_wd <= `CPE_WORD_EMPTY;
          work <= work + 8'h01;
          if (work == `CPE_ADDR_LAST) begin
            disp_addr <= `CPE_ADDR_FIRST;
            disp_op <= `CPE_OP_EMPTY;
            disp_sub <= `CPE_SUB_ZERO;
            disp_data <= `CPE_DATA_ZERO;
            disp_show <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_XRAM: begin
          state <= ST_XLAT;
        end
        ST_XLAT: begin
          xfer_addr <= work;
          xfer_wdata <= ram_rdata;
          xfer_req <= 1'b1;
          state <= ST_XREQ;
        end
        ST_XREQ: begin
          if (xfer_ack) begin
            xfer_req <= 1'b0;
            if (xfer_load) begin
              ram_we <= 1'b1;
              ram_wa <= work;
              ram_wd <= xfer_rdata;
            end
            if (xfer_verify && xfer_rdata != xfer_wdata) begin
              verify_fail <= 1'b1;
            end
            work <= work + 8'h01;
            if (work == `CPE_ADDR_LAST) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_XRAM;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // arming only on entry into program mode forces a full pass;
      // kept after the key decode so arming wins over a same-edge key
      if (in_prog && mode_prev != `CPE_MODE_PROG) begin
        ac_armed <= 1'b1;
        ac_step <= 2'h0;
      end else if (!in_prog) begin
        ac_armed <= 1'b0;
      end
    end
  end

endmodule // cpe_console_entry

// ### cpe_console_entry_properties.sv
// assertion checker for the console program entry block
`timescale 1ns/1ps
`include "cpe_console_regs.vh"
module cpe_console_entry_properties (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // keypad side
  input wire [1:0] mode_sel,
  // display side
  input wire [`CPE_ADDR_W-1:0] disp_addr,
  input wire beep,
  input wire busy,
  input wire verify_fail,
  // transfer port
  input wire xfer_req,
  input wire xfer_load,
  input wire [`CPE_ADDR_W-1:0] xfer_addr,
  input wire [`CPE_WORD_W-1:0] xfer_wdata,
  input wire xfer_ack
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  reg [3:0] away;
  reg [`CPE_ADDR_W-1:0] last_addr;
  reg seen;
  // selector passes two sync stages, so give it time
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      away <= 4'h0;
      last_addr <= 8'h00;
      seen <= 1'b0;
    end else begin
      if (mode_sel == `CPE_MODE_PROG) away <= 4'h0;
      else if (away != 4'hF) away <= away + 4'h1;
      if (xfer_ack) last_addr <= xfer_addr;
      if (xfer_ack) seen <= 1'b1;
    end
  end
  property p_beep_pulse; beep |=> !beep [*3]; endproperty
  a_beep_pulse: assert property (p_beep_pulse)
    else $error("beep too long");
  property p_beep_prog; beep |-> $past(mode_sel, 3) == `CPE_MODE_PROG; endproperty
  a_beep_prog: assert property (p_beep_prog)
    else $error("beep outside program mode");
  property p_idle_hold; away >= 4'h6 && !busy |=> $stable(disp_addr); endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("address moved outside program mode");
  property p_req_hold;
    xfer_req && !xfer_ack |=> xfer_req && $stable(xfer_addr) && $stable(xfer_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped early");
  property p_req_drop; xfer_ack |=> !xfer_req; endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("request held after ack");
  property p_busy_req; xfer_req |-> busy; endproperty
  a_busy_req: assert property (p_busy_req)
    else $error("transfer while not busy");
  property p_addr_step;
    $rose(xfer_req) && seen && xfer_addr != 8'h00 |-> xfer_addr == last_addr + 8'h01;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("transfer address skipped");
  property p_vf_cause;
    $rose(verify_fail) |-> $past(xfer_ack) || $past(xfer_ack, 2);
  endproperty
  a_vf_cause: assert property (p_vf_cause)
    else $error("compare flag without transfer");
  c_load: cover property ($rose(xfer_req) && xfer_load);
  c_vf: cover property ($rose(verify_fail));
  c_beeps: cover property (beep ##[4:40] beep);
endmodule // cpe_console_entry_properties

// ### cpe_xfer_store.sv
// eprom bank and cassette store behind the transfer port
`timescale 1ns/1ps
module cpe_xfer_store (
  // clock
  input wire ref_clk,
  // transfer port
  input wire xfer_req,
  input wire xfer_tape,
  input wire xfer_load,
  input wire [7:0] xfer_addr,
  input wire [19:0] xfer_wdata,
  output reg [19:0] xfer_rdata,
  output reg xfer_ack,
  // scenario controls
  input wire slow,
  input wire corrupt,
  input wire [7:0] bad_addr
);
  reg [19:0] store [0:1][0:255];
  integer wait_n;
  initial begin
    xfer_ack = 1'b0;
    xfer_rdata = 20'h00000;
    wait_n = 0;
  end
  // idle data toggles so a stale word is never read as valid
  always @(posedge ref_clk) begin
    xfer_ack <= 1'b0;
    xfer_rdata <= ~xfer_rdata;
    if (xfer_req && !xfer_ack) begin
      if (wait_n < (slow ? 3 : 0)) wait_n <= wait_n + 1;
      else begin
        wait_n <= 0;
        xfer_ack <= 1'b1;
        xfer_rdata <= store[xfer_tape][xfer_addr]
          ^ {19'h0, corrupt && xfer_addr == bad_addr};
        if (!xfer_load) store[xfer_tape][xfer_addr] <= xfer_wdata;
      end
    end
  end
endmodule // cpe_xfer_store

// ### cpe_console_entry_tb_top.sv
// self-checking bench for the console program entry block
`timescale 1ns/1ps
`include "cpe_console_regs.vh"
module cpe_console_entry_tb_top;
  reg ref_clk, resetn, key_strobe, slow, corrupt;
  reg [5:0] key_code;
  reg [1:0] mode_sel;
  reg [7:0] bad_addr;
  wire [7:0] disp_addr, xfer_addr;
  wire [4:0] disp_op;
  wire [2:0] disp_sub;
  wire [11:0] disp_data;
  wire [1:0] xfer_bank;
  wire [19:0] xfer_wdata, xfer_rdata;
  wire disp_show, beep, busy, verify_fail;
  wire xfer_req, xfer_tape, xfer_load, xfer_ack;
  reg [19:0] mem [0:255];
  reg [29:0] exp_q [$];
  reg [29:0] e;
  reg prev_busy;
  integer fail_count, num_checks, beeps, i, a;
  cpe_console_entry dut_u (.ref_clk, .resetn, .key_strobe, .key_code,
    .mode_sel, .disp_addr, .disp_op, .disp_sub, .disp_data, .disp_show,
    .beep, .busy, .verify_fail, .xfer_req, .xfer_tape, .xfer_load,
    .xfer_bank, .xfer_addr, .xfer_wdata, .xfer_rdata, .xfer_ack);
  cpe_xfer_store far_u (.ref_clk, .xfer_req, .xfer_tape, .xfer_load,
    .xfer_addr, .xfer_wdata, .xfer_rdata, .xfer_ack, .slow, .corrupt,
    .bad_addr);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task cmp_word(input [27:0] got, input [27:0] want);
    num_checks = num_checks + 1;
    if (got !== want) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task cmp_val(input [31:0] got, input [31:0] want);
    num_checks = num_checks + 1;
    if (got !== want) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // key code set an edge ahead of the strobe, then wait out busy
  task press(input integer c);
    integer n;
    key_code <= c[5:0];
    @(posedge ref_clk);
    key_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    key_strobe <= 1'b0;
    repeat (5) @(posedge ref_clk);
    for (n = 0; busy !== 1'b0 && n < 4000; n++) @(posedge ref_clk);
    if (n >= 4000) fail_count = fail_count + 1;
  endtask
  task dig3(input integer v);
    press(v / 100);
    press(v / 10 % 10);
    press(v % 10);
  endtask
  task push(input integer k, input integer ad, input [19:0] w);
    exp_q.push_back({k[1:0], ad[7:0], w});
  endtask
  task rd(input integer k, input integer ad);
    push(1, ad, mem[ad[7:0]]);
    press(k);
  endtask
  task xfer(input integer k, input integer vf);
    // bank comes from the data field last shown, the word at a+1
    push(2, mem[a + 1] & 20'h00003, vf[19:0]);
    press(k);
  endtask
  task entry(input integer ad, input integer drop);
    integer f, c, d;
    f = $urandom_range(15, 0);
    c = $urandom_range(7, 0);
    d = $urandom_range(999, 0);
    if (drop) begin
      press(32 + c);
      dig3(d);
      press(`CPE_KEY_DISCARD);
      cmp_val(32'(disp_op), 32'(`CPE_OP_EMPTY));
    end
    press(32 + f);
    press(48 + c);
    dig3(d);
    press(`CPE_KEY_WRITE);
    mem[ad] = {f[4:0], c[2:0], 4'(d / 100), 4'(d / 10 % 10), 4'(d % 10)};
    cmp_val(32'(disp_addr), ad + 1);
  endtask
  always @(posedge ref_clk) begin
    if (beep === 1'b1) beeps <= beeps + 1;
    if (prev_busy === 1'b1 && busy === 1'b0) begin
      if (exp_q.size() == 0) cmp_val(32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        if (e[29:28] == 2'd1)
          cmp_word({disp_addr, disp_op, disp_sub, disp_data}, e[27:0]);
        else if (e[29:28] == 2'd2) begin
          cmp_val(32'(verify_fail), 32'(e[0]));
          cmp_val(32'(xfer_bank), 32'(e[21:20]));
        end
      end
    end
    prev_busy <= busy;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count = fail_count + 1;
    wrap_up;
  end
  initial begin
    resetn = 1'b0;
    key_strobe = 1'b0;
    key_code = 6'h00;
    mode_sel = `CPE_MODE_PROG;
    slow = 1'b0;
    corrupt = 1'b0;
    bad_addr = 8'h00;
    prev_busy = 1'b0;
    fail_count = 0;
    num_checks = 0;
    beeps = 0;
    i = $urandom(32'hd5a9bdb2);
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    press(`CPE_AC_KEY0);
    press(`CPE_AC_KEY1);
    press(`CPE_AC_KEY2);
    push(1, 0, `CPE_WORD_EMPTY);
    press(`CPE_AC_KEY3);
    cmp_val(beeps, 4);
    for (i = 0; i < 256; i++) mem[i] = `CPE_WORD_EMPTY;
    $display("test clear done");
    press(`CPE_KEY_CLEAR);
    rd(`CPE_KEY_READ, 0);
    rd(`CPE_KEY_BACK, 255);
    rd(`CPE_KEY_FWD, 0);
    press(`CPE_KEY_CLEAR);
    dig3(259);
    cmp_val(32'(disp_show), 0);
    cmp_val(32'(disp_addr), 59);
    rd(`CPE_KEY_READ, 59);
    $display("test address done");
    a = $urandom_range(200, 1);
    press(`CPE_KEY_CLEAR);
    dig3(a);
    for (i = 0; i < 3; i++) entry(a + i, i == 1);
    press(`CPE_KEY_CLEAR);
    dig3(a);
    rd(`CPE_KEY_READ, a);
    rd(`CPE_KEY_FWD, a + 1);
    rd(`CPE_KEY_FWD, a + 2);
    rd(`CPE_KEY_BACK, a + 1);
    $display("test write done");
    bad_addr = a[7:0];
    xfer(`CPE_KEY_EPR_WR, 0);
    slow = 1'b1;
    xfer(`CPE_KEY_EPR_VF, 0);
    corrupt = 1'b1;
    xfer(`CPE_KEY_EPR_VF, 1);
    xfer(`CPE_KEY_EPR_RD, 0);
    mem[a] = mem[a] ^ 20'h00001;
    corrupt = 1'b0;
    xfer(`CPE_KEY_TAPE_WR, 0);
    xfer(`CPE_KEY_TAPE_VF, 0);
    xfer(`CPE_KEY_TAPE_RD, 0);
    press(`CPE_KEY_CLEAR);
    dig3(a);
    rd(`CPE_KEY_READ, a);
    $display("test transfer done");
    mode_sel <= `CPE_MODE_STOP;
    repeat (8) @(posedge ref_clk);
    i = beeps;
    press(`CPE_AC_KEY0);
    mode_sel <= `CPE_MODE_PROG;
    repeat (8) @(posedge ref_clk);
    press(`CPE_AC_KEY0);
    press(`CPE_AC_KEY1);
    press(`CPE_AC_KEY2);
    press(`CPE_KEY_CLEAR);
    press(`CPE_AC_KEY3);
    cmp_val(beeps - i, 3);
    press(`CPE_KEY_CLEAR);
    dig3(a);
    rd(`CPE_KEY_READ, a);
    $display("test abort done");
    cmp_val(exp_q.size(), 0);
    wrap_up;
  end
endmodule // cpe_console_entry_tb_top
bind cpe_console_entry cpe_console_entry_properties chk_u (.ref_clk,
  .resetn, .mode_sel, .disp_addr, .beep, .busy, .verify_fail, .xfer_req,
  .xfer_load, .xfer_addr, .xfer_wdata, .xfer_ack);
